// >>> rtl/rsc_strap_loader.v
// reset-time strap capture, link select and clock source selection
`timescale 1ns/1ps
`include "rsc_defs.vh"
// Operation
// - capture protocol and loader straps at reset, hold until next reset
// - loader strap high: 00 i2c, 01 robot uart, 10 transport uart, 11 spi
// - loader strap low starts bootloader; 01 combination is reserved
// - after reset in spi mode the low select pin becomes a wake input
// - strap a low crystal; a and b high external; a high b low internal
// - pull down strap a, sample it, drop pull-down when it reads high
// - only when strap a is high, pull down and sample strap b
// - drop strap b pull-down when it samples high
// - sources are internal oscillator, external 32.768 kHz clock or crystal
// - host interrupt output is active low
// - outside spi, address pin gives i2c target address bit zero
module rsc_strap_loader (
  input  wire       mclk,
  input  wire       arst_n,
  input  wire       loader_strap_n,
  input  wire       proto_sel_hi,
  input  wire       proto_sel_lo_wake,
  input  wire       addr_lsb_or_spi_in,
  input  wire       clk_src_strap_a,
  input  wire       xtal_out_clk_strap_b,
  input  wire       irq_req,
  output reg        strap_a_pull_en_q,
  output reg        strap_b_pull_en_q,
  output reg        strap_b_in_mode_q,
  output reg  [1:0] link_sel_q,
  output reg        loader_mode_q,
  output reg        link_reserved_q,
  output reg        link_valid_q,
  output reg  [1:0] clk_src_q,
  output reg        clk_valid_q,
  output reg  [6:0] i2c_addr_q,
  output reg        spi_wake_q,
  output reg        host_irq_n
);
  // straps as captured on the first edge after release
  reg        captured_q;
  reg  [1:0] proto_q;
  reg        loader_n_q;
  reg        addr_lsb_q;
  // probe launch requests, one per clock strap
  reg        start_a_q;
  reg        start_b_q;
  reg        start_a_d;
  reg        start_b_d;
  // next values of the link selection
  reg  [1:0] link_sel_d;
  reg        loader_mode_d;
  reg        link_reserved_d;
  reg  [6:0] i2c_addr_d;
  // next values of the clock, wake and interrupt outputs
  reg  [1:0] clk_src_d;
  reg        clk_valid_d;
  reg        spi_wake_d;
  reg        host_irq_n_d;
  // per-strap probe signals: index 0 is strap a, index 1 is strap b
  wire [1:0] probe_start;
  wire [1:0] probe_pin;
  wire [1:0] probe_pull;
  wire [1:0] probe_done;
  wire [1:0] probe_level;
  // named views of the probe results
  wire       pa_pull;
  wire       pa_done;
  wire       pa_level;
  wire       pb_pull;
  wire       pb_done;
  wire       pb_level;
  genvar     g;

  // one-shot capture on the first edge after reset release
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      captured_q <= 1'b0;
      proto_q    <= 2'h0;
      loader_n_q <= 1'b1;
      addr_lsb_q <= 1'b0;
    end else if (!captured_q) begin
      captured_q <= 1'b1;
      proto_q    <= {proto_sel_hi, proto_sel_lo_wake};
      loader_n_q <= loader_strap_n;
      addr_lsb_q <= addr_lsb_or_spi_in;
    end
  end

  // link decode from the captured straps
  always @* begin
    link_sel_d      = proto_q;
    loader_mode_d   = ~loader_n_q;
    // the robot code has no loader counterpart, so it is flagged
    link_reserved_d = ~loader_n_q && (proto_q == `RSC_LINK_ROBOT);
    // spi reuses the address pin as data, so the bit is left clear
    i2c_addr_d      = {`RSC_I2C_ADDR_HI,
                       addr_lsb_q && (proto_q != `RSC_LINK_SPI)};
  end

  // link outputs load once; later strap changes never reach them
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link_sel_q      <= `RSC_LINK_I2C;
      loader_mode_q   <= 1'b0;
      link_reserved_q <= 1'b0;
      link_valid_q    <= 1'b0;
      i2c_addr_q      <= 7'h00;
    end else if (captured_q && !link_valid_q) begin
      link_sel_q      <= link_sel_d;
      loader_mode_q   <= loader_mode_d;
      link_reserved_q <= link_reserved_d;
      link_valid_q    <= 1'b1;
      i2c_addr_q      <= i2c_addr_d;
    end
  end

  // wake follows the pin only once spi is fixed as the link
  always @* begin
    spi_wake_d   = link_valid_q && (link_sel_q == `RSC_LINK_SPI)
                   && proto_sel_lo_wake;
    // no request reaches the host before a link exists to serve it
    host_irq_n_d = ~(irq_req && link_valid_q);
  end

  // wake registered, so the host sees the pin one cycle late
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      spi_wake_q <= 1'b0;
    end else begin
      spi_wake_q <= spi_wake_d;
    end
  end

  // active-low host interrupt, idle high through reset
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      host_irq_n <= 1'b1;
    end else begin
      host_irq_n <= host_irq_n_d;
    end
  end

  // strap sequencing: probe a first, probe b only if a reads high
  always @* begin
    start_a_d = captured_q && !pa_done;
    start_b_d = pa_done && pa_level && !pb_done;
  end

  // start requests registered to keep the probe launch glitch free
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      start_a_q <= 1'b0;
      start_b_q <= 1'b0;
    end else begin
      start_a_q <= start_a_d;
      start_b_q <= start_b_d;
    end
  end

  // each strap gets its own probe instance; each index owns its pin and pull-down
  assign probe_start = {start_b_q, start_a_q};
  assign probe_pin   = {xtal_out_clk_strap_b, clk_src_strap_a};

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_probe
      rsc_clk_probe u_probe (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .start     (probe_start[g]),
        .strap_in  (probe_pin[g]),
        .pull_en_q (probe_pull[g]),
        .done_q    (probe_done[g]),
        .level_q   (probe_level[g])
      );
    end
  endgenerate

  // strap a results
  assign pa_pull  = probe_pull[0];
  assign pa_done  = probe_done[0];
  assign pa_level = probe_level[0];
  // strap b results
  assign pb_pull  = probe_pull[1];
  assign pb_done  = probe_done[1];
  assign pb_level = probe_level[1];

  // pin control registered again so outputs come from flops
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      strap_a_pull_en_q <= 1'b0;
      strap_b_pull_en_q <= 1'b0;
      strap_b_in_mode_q <= 1'b0;
    end else begin
      strap_a_pull_en_q <= pa_pull;
      strap_b_pull_en_q <= pb_pull;
      // crystal drive on strap b pin is left alone unless strap a is high
      strap_b_in_mode_q <= pa_done && pa_level;
    end
  end

  // clock source decision; keeping the oscillator off uart is the board's concern
  always @* begin
    clk_src_d   = clk_src_q;
    clk_valid_d = clk_valid_q;
    if (!clk_valid_q) begin
      if (pa_done && !pa_level) begin
        clk_src_d   = `RSC_CLK_XTAL;
        clk_valid_d = 1'b1;
      end else if (pb_done) begin
        clk_src_d   = pb_level ? `RSC_CLK_EXT : `RSC_CLK_INT;
        clk_valid_d = 1'b1;
      end
    end
  end

  // the decision holds until the next reset; nothing reopens it
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clk_src_q   <= `RSC_CLK_NONE;
      clk_valid_q <= 1'b0;
    end else begin
      clk_src_q   <= clk_src_d;
      clk_valid_q <= clk_valid_d;
    end
  end
endmodule

// >>> rtl/rsc_defs.vh
// constants for the reset strap and clock source selector
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
// host link encodings, {proto_sel_hi, proto_sel_lo_wake}
`define RSC_LINK_I2C       2'h0
`define RSC_LINK_ROBOT     2'h1
`define RSC_LINK_TRANSPORT 2'h2
`define RSC_LINK_SPI       2'h3
// clock source encodings
`define RSC_CLK_NONE       2'h0
`define RSC_CLK_XTAL       2'h1
`define RSC_CLK_EXT        2'h2
`define RSC_CLK_INT        2'h3
// i2c target address upper six bits
`define RSC_I2C_ADDR_HI    6'h25
// pull-down settle time before sampling a clock strap: 200 ns at 10 ns a cycle
`define RSC_SETTLE_CYC     8'h14
`define RSC_SETTLE_W       8
`endif

// >>> rtl/rsc_clk_probe.v
// clock strap probe: pull-down, wait, sample, release pull-down when high
`timescale 1ns/1ps
`include "rsc_defs.vh"
module rsc_clk_probe #(
  parameter [`RSC_SETTLE_W-1:0] SETTLE = `RSC_SETTLE_CYC
) (
  input  wire mclk,
  input  wire arst_n,
  input  wire start,
  input  wire strap_in,
  output reg  pull_en_q,
  output reg  done_q,
  output reg  level_q
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;
  reg [1:0]              state_q;
  reg [`RSC_SETTLE_W-1:0] cnt_q;

  // pull-down stays on for a low strap; a high strap would leak through it
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= ST_IDLE;
      cnt_q     <= {`RSC_SETTLE_W{1'b0}};
      pull_en_q <= 1'b0;
      done_q    <= 1'b0;
      level_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            pull_en_q <= 1'b1;
            cnt_q     <= SETTLE;
            state_q   <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cnt_q == {`RSC_SETTLE_W{1'b0}}) begin
            level_q   <= strap_in;
            pull_en_q <= ~strap_in;
            done_q    <= 1'b1;
            state_q   <= ST_DONE;
          end else begin
            cnt_q <= cnt_q - {{(`RSC_SETTLE_W-1){1'b0}}, 1'b1};
          end
        end
        ST_DONE: state_q <= ST_DONE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// >>> sim/rsc_chk.sv
// concurrent checks on the strap loader ports
`timescale 1ns/1ps
module rsc_chk (
  input wire       mclk,
  input wire       arst_n,
  input wire       irq_req,
  input wire       proto_sel_lo_wake,
  input wire       strap_a_pull_en_q,
  input wire       strap_b_pull_en_q,
  input wire       strap_b_in_mode_q,
  input wire [1:0] link_sel_q,
  input wire       loader_mode_q,
  input wire       link_reserved_q,
  input wire       link_valid_q,
  input wire [1:0] clk_src_q,
  input wire       clk_valid_q,
  input wire [6:0] i2c_addr_q,
  input wire       spi_wake_q,
  input wire       host_irq_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  chk_irq_low: assert property (irq_req && link_valid_q |=> !host_irq_n)
    else $error("host irq not driven low");
  chk_link_hold: assert property ($past(link_valid_q) |->
    $stable(link_sel_q) && $stable(loader_mode_q)) else $error("link choice moved");
  chk_clk_hold: assert property (clk_valid_q |=> clk_valid_q && $stable(clk_src_q))
    else $error("clock choice moved");
  chk_rsv_code: assert property (link_reserved_q |-> loader_mode_q && link_sel_q == 2'h1)
    else $error("reserved flag wrong");
  chk_wake_copy: assert property (link_valid_q && $past(link_valid_q) |->
    spi_wake_q == (link_sel_q == 2'h3 && $past(proto_sel_lo_wake))) else $error("wake wrong");
  chk_addr_bits: assert property (link_valid_q |-> i2c_addr_q[6:1] == 6'h25 &&
    !(link_sel_q == 2'h3 && i2c_addr_q[0])) else $error("address wrong");
  chk_a_release: assert property (clk_valid_q && clk_src_q != 2'h1 |-> !strap_a_pull_en_q)
    else $error("strap a pull left on");
  chk_b_order: assert property (clk_valid_q |-> strap_b_in_mode_q == (clk_src_q != 2'h1)
    && strap_b_pull_en_q == (clk_src_q == 2'h3)) else $error("strap b handling wrong");
  chk_a_pull_first: assert property ($rose(strap_b_in_mode_q) |->
    $past(strap_a_pull_en_q) && !strap_a_pull_en_q) else $error("strap a not probed first");
endmodule

// >>> sim/rsc_board.sv
// board model: clock straps tied high or left open with on-chip pulls
`timescale 1ns/1ps
module rsc_board (
  input  wire mclk,
  input  wire a_hi,
  input  wire b_hi,
  input  wire a_pull,
  input  wire b_pull,
  output reg  a_pin,
  output reg  b_pin
);
  initial a_pin = 1'h0;
  initial b_pin = 1'h0;
  // open pin toggles when unpulled, so a stale level never reads as valid
  always @(negedge mclk) begin
    a_pin <= a_hi | (!a_pull & !a_pin);
    b_pin <= b_hi | (!b_pull & !b_pin);
  end
endmodule

// >>> sim/tb.sv
// testbench: eight strap cases through reset, selections checked after
`timescale 1ns/1ps
module tb;
  reg        mclk, arst_n, loader_strap_n, proto_sel_hi, proto_sel_lo_wake;
  reg        addr_lsb_or_spi_in, irq_req, a_hi, b_hi;
  wire       clk_src_strap_a, xtal_out_clk_strap_b, strap_a_pull_en_q, strap_b_pull_en_q;
  wire       strap_b_in_mode_q, loader_mode_q, link_reserved_q, link_valid_q, clk_valid_q;
  wire       spi_wake_q, host_irq_n;
  wire [1:0] link_sel_q, clk_src_q;
  wire [6:0] i2c_addr_q;
  integer    errors, n_compared, i, k;
  rsc_strap_loader dut (
    .mclk                 (mclk),
    .arst_n               (arst_n),
    .loader_strap_n       (loader_strap_n),
    .proto_sel_hi         (proto_sel_hi),
    .proto_sel_lo_wake    (proto_sel_lo_wake),
    .addr_lsb_or_spi_in   (addr_lsb_or_spi_in),
    .clk_src_strap_a      (clk_src_strap_a),
    .xtal_out_clk_strap_b (xtal_out_clk_strap_b),
    .irq_req              (irq_req),
    .strap_a_pull_en_q    (strap_a_pull_en_q),
    .strap_b_pull_en_q    (strap_b_pull_en_q),
    .strap_b_in_mode_q    (strap_b_in_mode_q),
    .link_sel_q           (link_sel_q),
    .loader_mode_q        (loader_mode_q),
    .link_reserved_q      (link_reserved_q),
    .link_valid_q         (link_valid_q),
    .clk_src_q            (clk_src_q),
    .clk_valid_q          (clk_valid_q),
    .i2c_addr_q           (i2c_addr_q),
    .spi_wake_q           (spi_wake_q),
    .host_irq_n           (host_irq_n)
  );
  rsc_board brd (.mclk(mclk), .a_hi(a_hi), .b_hi(b_hi), .a_pull(strap_a_pull_en_q),
    .b_pull(strap_b_pull_en_q), .a_pin(clk_src_strap_a), .b_pin(xtal_out_clk_strap_b));
  task check(input [31:0] seen, input [31:0] exp, input [8*6-1:0] what);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("MISMATCH %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task stop_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  // watchdog: eight cases of at most about sixty-five cycles each
  initial begin
    #20000;
    errors = errors + 1;
    stop_test;
  end
  initial begin
    {errors, n_compared, arst_n, loader_strap_n, proto_sel_hi, proto_sel_lo_wake} = 0;
    {addr_lsb_or_spi_in, irq_req, a_hi, b_hi} = 0;
    for (i = 0; i < 8; i = i + 1) begin
      // internal oscillator only with i2c or spi, never a uart link
      @(negedge mclk);
      {loader_strap_n, proto_sel_hi, proto_sel_lo_wake} = i[2:0];
      addr_lsb_or_spi_in = (i[1:0] == 2'h3) | !i[0];
      irq_req = i[0];
      a_hi = i[1:0] != 2'h2;
      b_hi = i[1:0] == 2'h1 || i == 7;
      arst_n = 0;
      repeat (12) @(negedge mclk);
      arst_n = 1;
      // one edge after release: straps taken, nothing offered yet
      @(negedge mclk);
      check(host_irq_n, 1'h1, "irq");
      check(link_valid_q, 1'h0, "valid");
      for (k = 0; k < 200 && clk_valid_q !== 1'h1; k = k + 1) @(negedge mclk);
      check(spi_wake_q, i[1:0] == 2'h3, "wake");
      check(link_valid_q, 1'h1, "valid");
      // straps wander after capture; link and address must ignore them, wake must follow its pin
      {loader_strap_n, proto_sel_hi, addr_lsb_or_spi_in} = ~i[2:0];
      proto_sel_lo_wake = !proto_sel_lo_wake;
      repeat (3) @(negedge mclk);
      check(clk_valid_q, 1'h1, "done");
      check(link_sel_q, i[1:0], "link");
      check(loader_mode_q, !i[2], "loader");
      check(link_reserved_q, !i[2] && i[1:0] == 2'h1, "rsv");
      check(clk_src_q, a_hi ? (b_hi ? 2'h2 : 2'h3) : 2'h1, "clk");
      check(strap_a_pull_en_q, !a_hi, "pull_a");
      check({strap_b_in_mode_q, strap_b_pull_en_q}, {a_hi, a_hi & !b_hi}, "pull_b");
      check(i2c_addr_q, {6'h25, !i[0]}, "addr");
      check(spi_wake_q, i[1:0] == 2'h3 && proto_sel_lo_wake, "wake");
      check(host_irq_n, !i[0], "irq");
      $display("case %0d done", i);
    end
    stop_test;
  end
endmodule
bind rsc_strap_loader rsc_chk u_chk (.*);
